// file: rtl/dcr_dma_channel_control_regs.sv
`timescale 1ns/10ps
module dcr_dma_channel_control_regs
    import dcr_pkg::*;
#(
    parameter int unsigned CHANNELS = NUM_CHAN
)
(
    input wire logic mclk, // System clock, 100 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire dcr_sfr_req_s sfr_req, // Register bus access
    output logic [7:0] sfr_rdata, // Read data, one cycle after rd
    input wire dcr_eng_stat_s eng_stat, // Status from data mover
    input wire logic [4:0] trigger_event, // Trigger pulses per channel
    input wire logic [1:0] active_priority, // Priority of channel asking for bus
    input wire logic dma_bus_req, // Data mover wants the memory bus
    input wire logic cpu_bus_req, // Processor wants the memory bus
    output logic dma_bus_win, // Data mover gets the memory bus
    output logic [4:0] xfer_request, // Armed and triggered, per channel
    output logic [4:0] channel_armed, // Arm bits
    output logic [4:0] manual_trigger_bit, // Manual trigger bits
    output logic [4:0] abort_pulse, // Stop ongoing transfer, one cycle
    output logic [4:0] count_done_flag, // Interrupt flags
    output logic dma_irq, // Any flag pending
    output logic [15:0] chan0_cfg_pointer, // Channel 0 record address
    output logic [79:0] cfg_fetch_addr // Record address per channel, 16 bits each
);

    // Register map is hard-wired for five channels, so refuse any other count
    if (CHANNELS != NUM_CHAN)
    begin : g_bad_channels
        $error("Only five channels are supported");
    end

    dcr_state_s st_reg;
    dcr_state_s st_next;
    logic wr_arm;
    logic wr_trig;
    logic wr_irq;

    // Address decode for one register
    function automatic logic hit(input dcr_sfr_req_s r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction

    // Record address of channel n, n from 1 to 4
    function automatic logic [15:0] rec_addr(input logic [15:0] base, input logic [2:0] n);
        logic [15:0] idx;
        idx = {13'h0000, n - 3'h1};
        rec_addr = 16'(base + idx * CFG_RECORD_BYTES);
    endfunction

    assign wr_arm = hit(sfr_req, OFS_ARM_ABORT);
    assign wr_trig = hit(sfr_req, OFS_MANUAL_TRIGGER);
    assign wr_irq = hit(sfr_req, OFS_IRQ_FLAGS);

    // Next-state logic for the whole block
    always_comb
    begin
        logic [4:0] sel;
        logic [4:0] flag_set;
        sel = sfr_req.wdata[4:0];
        flag_set = eng_stat.count_done & eng_stat.done_irq_enable;
        st_next = st_reg;
        st_next.abort_pulse = 5'h00;

        // Arm bits: count reached disarms unless in repeat mode, a software write lands last so its set wins
        st_next.channel_armed = st_reg.channel_armed
            & ~(eng_stat.count_done & ~eng_stat.repeat_mode);
        if (wr_arm)
        begin
            if (sfr_req.wdata[ABORT_BIT])
            begin
                st_next.channel_armed = st_next.channel_armed & ~sel;
                st_next.abort_pulse = sel;
            end
            else
            begin
                st_next.channel_armed = sel;
            end
        end

        // Manual trigger: write 1 sets, grant clears, set wins the same cycle
        st_next.manual_trigger_bit = st_reg.manual_trigger_bit & ~eng_stat.grant;
        if (wr_trig)
        begin
            st_next.manual_trigger_bit = st_next.manual_trigger_bit | sel;
        end

        // Flags: a write of 0 clears, hardware set wins over the clear
        st_next.count_done_flag = st_reg.count_done_flag;
        if (wr_irq)
        begin
            st_next.count_done_flag = st_reg.count_done_flag & sel;
        end
        st_next.count_done_flag = st_next.count_done_flag | flag_set;

        // Pointer byte registers
        if (hit(sfr_req, OFS_CHAN0_CFG_LOW))
        begin
            st_next.chan0_cfg_pointer[7:0] = sfr_req.wdata;
        end
        if (hit(sfr_req, OFS_CHAN0_CFG_HIGH))
        begin
            st_next.chan0_cfg_pointer[15:8] = sfr_req.wdata;
        end
        if (hit(sfr_req, OFS_SHARED_CFG_LOW))
        begin
            st_next.shared_cfg_pointer[7:0] = sfr_req.wdata;
        end
        if (hit(sfr_req, OFS_SHARED_CFG_HIGH))
        begin
            st_next.shared_cfg_pointer[15:8] = sfr_req.wdata;
        end

        // Normal priority: after a loss the next contest is won
        if (dma_bus_req && cpu_bus_req && active_priority == PRIO_NORMAL)
        begin
            st_next.normal_turn = ~st_reg.normal_turn;
        end

        // Read data; abort and unused bits answer zero
        st_next.rdata = 8'h00;
        if (sfr_req.rd)
        begin
            case (sfr_req.addr)
                OFS_IRQ_FLAGS: st_next.rdata = {3'h0, st_reg.count_done_flag};
                OFS_SHARED_CFG_LOW: st_next.rdata = st_reg.shared_cfg_pointer[7:0];
                OFS_SHARED_CFG_HIGH: st_next.rdata = st_reg.shared_cfg_pointer[15:8];
                OFS_CHAN0_CFG_LOW: st_next.rdata = st_reg.chan0_cfg_pointer[7:0];
                OFS_CHAN0_CFG_HIGH: st_next.rdata = st_reg.chan0_cfg_pointer[15:8];
                OFS_ARM_ABORT: st_next.rdata = {3'h0, st_reg.channel_armed};
                OFS_MANUAL_TRIGGER: st_next.rdata = {3'h0, st_reg.manual_trigger_bit};
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg <= '{channel_armed: ARM_RESET, manual_trigger_bit: TRIG_RESET,
                        count_done_flag: IRQ_RESET, chan0_cfg_pointer: CFG_ADDR_RESET,
                        shared_cfg_pointer: CFG_ADDR_RESET, abort_pulse: 5'h00,
                        normal_turn: 1'b0, rdata: 8'h00};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Bus arbitration against the processor; reserved code behaves as low
    always_comb
    begin
        case (active_priority)
            PRIO_HIGH: dma_bus_win = dma_bus_req;
            PRIO_NORMAL: dma_bus_win = dma_bus_req && (!cpu_bus_req || st_reg.normal_turn);
            default: dma_bus_win = dma_bus_req && !cpu_bus_req;
        endcase
    end

    // Transfers are gated by the arm bit; an abort cycle blocks them too
    assign xfer_request = st_reg.channel_armed & ~st_reg.abort_pulse
        & (trigger_event | st_reg.manual_trigger_bit);

    assign sfr_rdata = st_reg.rdata;
    assign channel_armed = st_reg.channel_armed;
    assign manual_trigger_bit = st_reg.manual_trigger_bit;
    assign abort_pulse = st_reg.abort_pulse;
    assign count_done_flag = st_reg.count_done_flag;
    assign dma_irq = |st_reg.count_done_flag;
    assign chan0_cfg_pointer = st_reg.chan0_cfg_pointer;

    // Record addresses; one adder per channel 1 to 4 trades area for zero latency
    assign cfg_fetch_addr[15:0] = st_reg.chan0_cfg_pointer;
    for (genvar g = 1; g < NUM_CHAN; g++)
    begin : g_rec
        assign cfg_fetch_addr[g*16 +: 16] = rec_addr(st_reg.shared_cfg_pointer, 3'(g));
    end

    property p_abort;
        @(posedge mclk) disable iff (!resetn)
        (wr_arm && sfr_req.wdata[ABORT_BIT]) |=>
            ((channel_armed & $past(sfr_req.wdata[4:0])) == 5'h00)
            && (abort_pulse == $past(sfr_req.wdata[4:0]));
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not disarm");

    // Unarmed and not armed by this write: no request may appear next cycle
    property p_gate;
        @(posedge mclk) disable iff (!resetn)
        (!channel_armed[2] && !(wr_arm && !sfr_req.wdata[ABORT_BIT] && sfr_req.wdata[2]))
            |=> !xfer_request[2];
    endproperty
    a_gate: assert property (p_gate) else $error("transfer on unarmed channel");

    property p_autoclr;
        @(posedge mclk) disable iff (!resetn)
        (eng_stat.count_done[0] && !eng_stat.repeat_mode[0] && !wr_arm) |=> !channel_armed[0];
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("arm not cleared at count");

    property p_trig;
        @(posedge mclk) disable iff (!resetn)
        (wr_trig && sfr_req.wdata[2]) |=> manual_trigger_bit[2]
            && (!channel_armed[2] || xfer_request[2] || abort_pulse[2]);
    endproperty
    a_trig: assert property (p_trig) else $error("manual trigger lost");

    property p_grant;
        @(posedge mclk) disable iff (!resetn)
        (eng_stat.grant[1] && !(wr_trig && sfr_req.wdata[1])) |=> !manual_trigger_bit[1];
    endproperty
    a_grant: assert property (p_grant) else $error("trigger not cleared on grant");

    property p_ptr0;
        @(posedge mclk) disable iff (!resetn)
        hit(sfr_req, OFS_CHAN0_CFG_HIGH) |=> chan0_cfg_pointer[15:8] == $past(sfr_req.wdata);
    endproperty
    a_ptr0: assert property (p_ptr0) else $error("channel 0 pointer wrong");

    property p_rec;
        @(posedge mclk) disable iff (!resetn)
        cfg_fetch_addr[79:64] == 16'(st_reg.shared_cfg_pointer + 16'h0018);
    endproperty
    a_rec: assert property (p_rec) else $error("channel 4 record address wrong");

    property p_flag;
        @(posedge mclk) disable iff (!resetn)
        (eng_stat.count_done[3] && eng_stat.done_irq_enable[3]) |=> count_done_flag[3] && dma_irq;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set at count");

    property p_clr;
        @(posedge mclk) disable iff (!resetn)
        (wr_irq && count_done_flag[0] && sfr_req.wdata[0]) |=> count_done_flag[0];
    endproperty
    a_clr: assert property (p_clr) else $error("write of 1 changed flag");

    property p_mask;
        @(posedge mclk) disable iff (!resetn)
        (!count_done_flag[0] && !eng_stat.done_irq_enable[0]) |=> !count_done_flag[0];
    endproperty
    a_mask: assert property (p_mask) else $error("masked channel raised flag");

    property p_prio;
        @(posedge mclk) disable iff (!resetn)
        (dma_bus_req && cpu_bus_req && active_priority == PRIO_NORMAL && !dma_bus_win)
            ##1 (dma_bus_req && cpu_bus_req && active_priority == PRIO_NORMAL) |-> dma_bus_win;
    endproperty
    a_prio: assert property (p_prio) else $error("normal priority lost twice");

    property p_rd;
        @(posedge mclk) disable iff (!resetn)
        (sfr_req.rd && sfr_req.addr == OFS_ARM_ABORT) |=> sfr_rdata[7:5] == 3'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("abort bit read nonzero");

endmodule

// file: rtl/dcr_pkg.sv
package dcr_pkg;
    // Channel count and register widths
    localparam int unsigned NUM_CHAN = 5;
    localparam int unsigned SFR_W = 8;
    // Register offsets on the special function register bus
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'hd1;
    localparam logic [7:0] OFS_SHARED_CFG_LOW = 8'hd2;
    localparam logic [7:0] OFS_SHARED_CFG_HIGH = 8'hd3;
    localparam logic [7:0] OFS_CHAN0_CFG_LOW = 8'hd4;
    localparam logic [7:0] OFS_CHAN0_CFG_HIGH = 8'hd5;
    localparam logic [7:0] OFS_ARM_ABORT = 8'hd6;
    localparam logic [7:0] OFS_MANUAL_TRIGGER = 8'hd7;
    // Field positions
    localparam int unsigned ABORT_BIT = 7;
    localparam int unsigned CHAN_LSB = 0;
    // Reset values
    localparam logic [4:0] ARM_RESET = 5'h00;
    localparam logic [4:0] TRIG_RESET = 5'h00;
    localparam logic [4:0] IRQ_RESET = 5'h00;
    localparam logic [15:0] CFG_ADDR_RESET = 16'h0000;
    // Size of one configuration record in memory
    localparam logic [15:0] CFG_RECORD_BYTES = 16'h0008;
    // Channel priority codes
    typedef enum logic [1:0] {
        PRIO_LOW = 2'h0,
        PRIO_NORMAL = 2'h1,
        PRIO_HIGH = 2'h2,
        PRIO_RSVD = 2'h3
    } dcr_prio_e;
    // One access on the special function register bus
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } dcr_sfr_req_s;
    // Per-channel status from the data mover
    typedef struct packed {
        logic [4:0] grant;
        logic [4:0] count_done;
        logic [4:0] repeat_mode;
        logic [4:0] done_irq_enable;
    } dcr_eng_stat_s;
    // Whole state of the control block
    typedef struct packed {
        logic [4:0] channel_armed;
        logic [4:0] manual_trigger_bit;
        logic [4:0] count_done_flag;
        logic [15:0] chan0_cfg_pointer;
        logic [15:0] shared_cfg_pointer;
        logic [4:0] abort_pulse;
        logic normal_turn;
        logic [7:0] rdata;
    } dcr_state_s;
endpackage

// file: tb/dcr_eng_model.sv
`timescale 1ns/10ps
module dcr_eng_model
    import dcr_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic resetn, // Reset, active low
    input wire logic [4:0] xfer_request, // Channel requests from the block
    input wire logic stall, // Hold off every grant while high
    input wire logic [4:0] repeat_mode, // Transfer mode per channel
    input wire logic [4:0] irq_mask, // Record interrupt mask per channel
    output dcr_eng_stat_s eng_stat // Status back to the block
);
    logic [4:0] grant_reg;
    // One-unit records, so every grant also reaches the count; no regrant while granting
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            grant_reg <= 5'h00;
        else
            grant_reg <= xfer_request & ~grant_reg & {5{~stall}};
    end
    // Status fields as the mover presents them
    always_comb
    begin
        eng_stat.grant = grant_reg;
        eng_stat.count_done = grant_reg;
        eng_stat.repeat_mode = repeat_mode;
        eng_stat.done_irq_enable = irq_mask;
    end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import dcr_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    dcr_sfr_req_s sfr_req = '0;
    logic [4:0] trigger_event = 5'h00;
    logic [1:0] active_priority = 2'h0;
    logic dma_bus_req = 1'b0;
    logic cpu_bus_req = 1'b0;
    logic stall = 1'b0;
    logic [4:0] rep = 5'h00;
    logic [4:0] irqm = 5'h1f;
    logic [7:0] sfr_rdata;
    dcr_eng_stat_s eng_stat;
    logic dma_bus_win, dma_irq;
    logic [4:0] xfer_request, channel_armed, manual_trigger_bit, abort_pulse, count_done_flag;
    logic [15:0] chan0_cfg_pointer;
    logic [79:0] cfg_fetch_addr;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int grants = 0;
    dcr_dma_channel_control_regs i_dcr_dma_channel_control_regs (.mclk(mclk), .resetn(resetn),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .eng_stat(eng_stat),
        .trigger_event(trigger_event), .active_priority(active_priority),
        .dma_bus_req(dma_bus_req), .cpu_bus_req(cpu_bus_req), .dma_bus_win(dma_bus_win),
        .xfer_request(xfer_request), .channel_armed(channel_armed),
        .manual_trigger_bit(manual_trigger_bit), .abort_pulse(abort_pulse),
        .count_done_flag(count_done_flag), .dma_irq(dma_irq),
        .chan0_cfg_pointer(chan0_cfg_pointer), .cfg_fetch_addr(cfg_fetch_addr));
    dcr_eng_model i_dcr_eng_model (.mclk(mclk), .resetn(resetn), .xfer_request(xfer_request),
        .stall(stall), .repeat_mode(rep), .irq_mask(irqm), .eng_stat(eng_stat));
    // 100 MHz clock
    always #5 mclk = ~mclk;
    // Hang guard and grant tally; a grant is a one-cycle pulse
    always @(posedge mclk)
    begin
        cycles++;
        if (eng_stat.grant !== 5'h00)
            grants++;
        if (cycles == 5000)
        begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits end just past an edge so outputs are settled when compared
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_req.addr <= a;
        sfr_req.wdata <= d;
        sfr_req.wr <= 1'b1;
        @(posedge mclk);
        sfr_req.wr <= 1'b0;
        #1;
    endtask
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        sfr_req.addr <= a;
        sfr_req.rd <= 1'b1;
        @(posedge mclk);
        sfr_req.rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask
    task automatic t_regs();
        logic [7:0] v;
        for (int a = 8'hd0; a <= 8'hd7; a++)
        begin
            sfr_rd(a[7:0], v);
            check("reset read", 16'(v), 16'h0000);
        end
        sfr_wr(8'hd0, 8'hff);
        sfr_rd(8'hd0, v);
        check("unmapped read", 16'(v), 16'h0000);
        sfr_wr(OFS_ARM_ABORT, 8'h7f);
        sfr_rd(OFS_ARM_ABORT, v);
        check("arm read", 16'(v), 16'h001f);
        check("no trigger request", 16'(xfer_request), 16'h0000);
        sfr_wr(OFS_ARM_ABORT, 8'h00);
    endtask
    task automatic t_ptr();
        logic [7:0] v;
        logic [15:0] exp_addr;
        sfr_wr(OFS_CHAN0_CFG_LOW, 8'h34);
        sfr_wr(OFS_CHAN0_CFG_HIGH, 8'h12);
        sfr_wr(OFS_SHARED_CFG_LOW, 8'hfc);
        sfr_wr(OFS_SHARED_CFG_HIGH, 8'hab);
        check("chan0 pointer", chan0_cfg_pointer, 16'h1234);
        check("fetch chan0", cfg_fetch_addr[15:0], 16'h1234);
        // Low byte near the top so later records carry into the high byte
        for (int n = 1; n < 5; n++)
        begin
            exp_addr = 16'habfc + 16'(8 * (n - 1));
            check("fetch shared", cfg_fetch_addr[16*n +: 16], exp_addr);
        end
        sfr_rd(OFS_SHARED_CFG_HIGH, v);
        check("shared high read", 16'(v), 16'h00ab);
    endtask
    task automatic t_manual();
        logic [7:0] v;
        for (int ch = 0; ch < 5; ch++)
        begin
            sfr_wr(OFS_ARM_ABORT, 8'h01 << ch);
            @(posedge mclk);
            stall <= 1'b1;
            sfr_wr(OFS_MANUAL_TRIGGER, 8'h01 << ch);
            cyc(3);
            check("held trigger", 16'(manual_trigger_bit), 16'(8'h01 << ch));
            check("trigger request", 16'(xfer_request), 16'(8'h01 << ch));
            @(posedge mclk);
            stall <= 1'b0;
            for (int i = 0; i < 20 && channel_armed[ch] !== 1'b0; i++)
                cyc(1);
            check("trigger cleared", 16'(manual_trigger_bit), 16'h0000);
            check("auto disarm", 16'(channel_armed), 16'h0000);
            check("flag set", 16'(count_done_flag), 16'(8'h01 << ch));
            check("irq line", 16'(dma_irq), 16'h0001);
            sfr_rd(OFS_IRQ_FLAGS, v);
            check("flag read", 16'(v), 16'(8'h01 << ch));
            sfr_wr(OFS_IRQ_FLAGS, 8'hff);
            check("flag kept", 16'(count_done_flag), 16'(8'h01 << ch));
            sfr_wr(OFS_IRQ_FLAGS, ~(8'h01 << ch));
            check("flag cleared", 16'(count_done_flag), 16'h0000);
        end
    endtask
    task automatic t_abort();
        logic [7:0] v;
        int g;
        g = grants;
        sfr_wr(OFS_MANUAL_TRIGGER, 8'h04);
        cyc(4);
        check("unarmed grants", 16'(grants - g), 16'h0000);
        check("unarmed trigger", 16'(manual_trigger_bit), 16'h0004);
        @(posedge mclk);
        stall <= 1'b1;
        sfr_wr(OFS_ARM_ABORT, 8'h1f);
        check("armed request", 16'(xfer_request), 16'h0004);
        sfr_wr(OFS_ARM_ABORT, 8'h85);
        check("abort disarm", 16'(channel_armed), 16'h001a);
        check("abort pulse", 16'(abort_pulse), 16'h0005);
        check("aborted request", 16'(xfer_request), 16'h0000);
        cyc(1);
        check("abort pulse end", 16'(abort_pulse), 16'h0000);
        sfr_rd(OFS_ARM_ABORT, v);
        check("abort reads zero", 16'(v), 16'h001a);
        sfr_wr(OFS_ARM_ABORT, 8'h00);
        @(posedge mclk);
        stall <= 1'b0;
    endtask
    task automatic t_done_irq_enable();
        int g;
        for (int r = 1; r >= 0; r--)
        begin
            g = grants;
            @(posedge mclk);
            irqm <= 5'h00;
            rep <= 5'(r);
            sfr_wr(OFS_ARM_ABORT, 8'h01);
            @(posedge mclk);
            trigger_event <= 5'h01;
            @(posedge mclk);
            trigger_event <= 5'h00;
            cyc(4);
            check("event grant", 16'(grants - g), 16'h0001);
            check("mode disarm", 16'(channel_armed), 16'(r));
            check("masked flag", 16'(count_done_flag), 16'h0000);
        end
    endtask
    task automatic t_prio();
        logic [1:0] w;
        for (int p = 0; p < 4; p++)
        begin
            @(posedge mclk);
            dma_bus_req <= 1'b1;
            cpu_bus_req <= 1'b1;
            active_priority <= p[1:0];
            cyc(1);
            w[0] = dma_bus_win;
            cyc(1);
            w[1] = dma_bus_win;
            if (p == 1)
                check("normal share", 16'(w[0] ^ w[1]), 16'h0001);
            else
                check("priority win", 16'(w), (p == 2) ? 16'h0003 : 16'h0000);
        end
    endtask
    // Main sequence
    initial
    begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_ptr();
        t_manual();
        t_abort();
        t_done_irq_enable();
        t_prio();
        summarize();
    end
endmodule
